// ===== rtl/slot_power_regs.svh
// Timing constants for the slot power host controller.
`ifndef SLOT_POWER_REGS_SVH
`define SLOT_POWER_REGS_SVH

// Clock rate in MHz (period of 5 ns).
`define SPH_CLK_MHZ        200
// Extra cold-start reset hold after power good rises, in microseconds.
`define SPH_COLD_HOLD_US   100
// Least warm reset pulse width, in microseconds.
`define SPH_WARM_PULSE_US  100
// Width of the shared delay counter.
`define SPH_CNT_W          16
// Reset values of the driven control pins (all low, aux not yet valid).
`define SPH_PINS_RESET     3'h0

`endif

// ===== rtl/slot_power_pkg.sv
// Types shared by the slot power host controller.
package slot_power_pkg;

  // Control pins that the controller drives toward the switch.
  typedef struct packed {
    logic host_reset_n;
    logic shutdown_request_n;
    logic standby_request_n;
  } ctrl_pins_t;

  // Status pins that the switch and the card drive toward the controller.
  typedef struct packed {
    logic card_reset_n;
    logic overcurrent_flag_n;
    logic usb_card_present_n;
    logic pcie_card_present_n;
  } stat_pins_t;

  // Decoded slot status presented to the user side.
  typedef struct packed {
    logic card_present;
    logic usb_card;
    logic pcie_card;
    logic power_good;
    logic card_in_reset;
    logic overcurrent;
  } slot_status_t;

  // Host reset sequencing states.
  typedef enum logic [1:0] {
    RST_IDLE,
    RST_COLD,
    RST_WARM
  } rst_state_t;

endpackage

// ===== rtl/slot_power_host.sv
// Host-side controller that drives the card slot power switch pins.
`timescale 1ns/100ps
`include "slot_power_regs.svh"
module slot_power_host #(
  parameter int COLD_HOLD_CYC = `SPH_COLD_HOLD_US * `SPH_CLK_MHZ,
  parameter int WARM_CYC      = `SPH_WARM_PULSE_US * `SPH_CLK_MHZ
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      clk_en,
  input  wire logic                      aux_valid,
  input  wire logic                      user_shutdown,
  input  wire logic                      user_standby,
  input  wire logic                      user_warm_reset,
  input  wire logic                      user_cold_extend,
  input  wire logic                      user_hold_power_good,
  output slot_power_pkg::ctrl_pins_t     ctrl_pins,
  input  wire slot_power_pkg::stat_pins_t stat_pins,
  input  wire logic                      refclk_enable_power_good_i,
  output logic                           refclk_enable_power_good_o,
  output logic                           refclk_enable_power_good_oe,
  output slot_power_pkg::slot_status_t   slot_status,
  output logic                           warm_busy
);
  import slot_power_pkg::*;

  localparam logic [`SPH_CNT_W-1:0] COLD_LAST =
    `SPH_CNT_W'(COLD_HOLD_CYC - 1);
  localparam logic [`SPH_CNT_W-1:0] WARM_LAST =
    `SPH_CNT_W'(WARM_CYC - 1);

  rst_state_t             state_q;
  logic [`SPH_CNT_W-1:0]  cnt_q;
  logic                   pg_q;
  ctrl_pins_t             pins_q;
  logic                   oe_q;
  slot_status_t           status_q;

  // Presence decode, used for both status bits and the combined flag.
  function automatic logic present(input logic pin_n);
    return ~pin_n;
  endfunction

  // Host reset sequencer: cold-start stretch and timed warm pulses.
  // The counter is shared; a warm request during a cold hold is dropped
  // because the card is already held in reset then.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= RST_IDLE;
      cnt_q   <= '0;
    end else if (clk_en) begin
      unique case (state_q)
        RST_IDLE: begin
          cnt_q <= '0;
          if (aux_valid && user_cold_extend &&
              refclk_enable_power_good_i && !pg_q) begin
            state_q <= RST_COLD;
          end else if (aux_valid && user_warm_reset) begin
            state_q <= RST_WARM;
          end
        end
        RST_COLD: begin
          cnt_q <= cnt_q + `SPH_CNT_W'(1);
          if (!aux_valid || cnt_q == COLD_LAST) begin
            state_q <= RST_IDLE;
          end
        end
        RST_WARM: begin
          cnt_q <= cnt_q + `SPH_CNT_W'(1);
          if (!aux_valid || cnt_q == WARM_LAST) begin
            state_q <= RST_IDLE;
          end
        end
        // The fourth code of the state word is never reached on purpose.
        default: begin
          state_q <= RST_IDLE;
        end
      endcase
    end
  end

  // Power good history, used to spot its low-to-high edge.
  always_ff @(posedge clk) begin
    if (reset) begin
      pg_q <= 1'b0;
    end else if (clk_en) begin
      pg_q <= refclk_enable_power_good_i;
    end
  end

  // Control pins. Nothing leaves low until aux is valid, since the
  // switch cannot tolerate high inputs before its own supply is up.
  always_ff @(posedge clk) begin
    if (reset) begin
      pins_q <= `SPH_PINS_RESET;
    end else if (clk_en) begin
      if (!aux_valid) begin
        pins_q <= `SPH_PINS_RESET;
      end else begin
        pins_q.host_reset_n       <= (state_q == RST_IDLE) &&
                                     !user_warm_reset;
        pins_q.shutdown_request_n <= !user_shutdown;
        pins_q.standby_request_n  <= !user_standby;
      end
    end
  end

  // Power good pin pull-down, driven only on the user's hold request.
  always_ff @(posedge clk) begin
    if (reset) begin
      oe_q <= 1'b0;
    end else if (clk_en) begin
      oe_q <= user_hold_power_good;
    end
  end

  // Status snapshot for the user side.
  always_ff @(posedge clk) begin
    if (reset) begin
      status_q <= '0;
    end else if (clk_en) begin
      // either presence pin means a card
      status_q.usb_card      <= present(stat_pins.usb_card_present_n);
      status_q.pcie_card     <= present(stat_pins.pcie_card_present_n);
      status_q.card_present  <= present(stat_pins.usb_card_present_n) |
                                present(stat_pins.pcie_card_present_n);
      status_q.power_good    <= refclk_enable_power_good_i;
      status_q.card_in_reset <= !stat_pins.card_reset_n;
      status_q.overcurrent   <= !stat_pins.overcurrent_flag_n;
    end
  end

  // The pin is open drain from our side: the data is fixed low.
  // never drive the line high
  assign refclk_enable_power_good_o  = 1'b0;
  assign refclk_enable_power_good_oe = oe_q;
  assign ctrl_pins                   = pins_q;
  assign slot_status                 = status_q;
  assign warm_busy                   = (state_q != RST_IDLE);

  chk_aux_gates_pins: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && !aux_valid |=> ctrl_pins == `SPH_PINS_RESET)
    else $error("control pin high while aux supply invalid");

  // shutdown and standby pins follow requests once aux is valid.
  chk_pins_follow: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && aux_valid
    |=> ctrl_pins.shutdown_request_n != $past(user_shutdown) &&
        ctrl_pins.standby_request_n != $past(user_standby))
    else $error("shutdown or standby pin does not follow request");

  chk_pg_never_high: assert property (
    @(posedge clk) disable iff (reset)
    refclk_enable_power_good_oe |-> !refclk_enable_power_good_o)
    else $error("power good line driven high");

  chk_pg_hold_follows: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && user_hold_power_good |=> refclk_enable_power_good_oe)
    else $error("power good hold request not applied");

  // line let go after the hold.
  chk_pg_release: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && !user_hold_power_good |=> !refclk_enable_power_good_oe)
    else $error("power good line held without request");

  chk_cold_stretch: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && state_q == RST_IDLE && aux_valid && user_cold_extend &&
    refclk_enable_power_good_i && !pg_q
    |=> state_q == RST_COLD)
    else $error("cold-start reset stretch not started");

  chk_cold_pin_low: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && state_q == RST_COLD && aux_valid
    |=> !ctrl_pins.host_reset_n)
    else $error("host reset pin high during cold stretch");

  chk_freeze_state: assert property (
    @(posedge clk) disable iff (reset)
    !clk_en |=> $stable(state_q) && $stable(cnt_q) && $stable(ctrl_pins))
    else $error("state moved while clock enable low");

  chk_warm_width: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && state_q == RST_IDLE && aux_valid && !user_cold_extend &&
    user_warm_reset ##1 clk_en[*2]
    |-> !ctrl_pins.host_reset_n)
    else $error("warm reset pulse not held low");

endmodule

// ===== test/slot_switch_model.sv
// Behavioural model of the card slot power switch facing the controller.
`timescale 1ns/100ps
module slot_switch_model
  import slot_power_pkg::*;
#(
  parameter int REL_CYC = 40,
  parameter int DG_CYC  = 8,
  parameter int LOW_CYC = 4
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire ctrl_pins_t ctrl_pins,
  output stat_pins_t      stat_pins,
  input  wire logic       pg_line,
  output logic            pg_oe,
  input  wire logic       usb_n,
  input  wire logic       pcie_n,
  input  wire logic       oc_in
);
  logic [2:0] rails;
  logic       present;
  logic       oc_q;
  int         rel_cnt;
  int         dg_cnt;
  logic       rst_raw;
  int         low_cnt;
  assign present = !usb_n || !pcie_n;
  always_comb begin
    if (!ctrl_pins.shutdown_request_n) rails = 3'h0;
    else if (!ctrl_pins.standby_request_n) rails = present ? 3'h4 : 3'h0;
    else rails = present ? 3'h7 : 3'h0;
  end
  assign pg_oe = rails != 3'h7;
  // release timer, shortened so the run stays brief.
  always_ff @(posedge clk) begin
    if (reset || !pg_line) rel_cnt <= REL_CYC;
    else if (rel_cnt != 0) rel_cnt <= rel_cnt - 1;
  end
  assign rst_raw = ctrl_pins.host_reset_n && pg_line && rel_cnt == 0;
  // least low time of every card reset pulse, also shortened.
  always_ff @(posedge clk) begin
    if (reset || !rst_raw) low_cnt <= LOW_CYC;
    else if (low_cnt != 0) low_cnt <= low_cnt - 1;
  end
  assign stat_pins.card_reset_n = rst_raw && low_cnt == 0;
  always_ff @(posedge clk) begin
    if (reset) begin
      oc_q   <= 1'b0;
      dg_cnt <= 0;
    end else if (oc_in != oc_q) begin
      dg_cnt <= (dg_cnt == DG_CYC - 1) ? 0 : dg_cnt + 1;
      if (dg_cnt == DG_CYC - 1) oc_q <= oc_in;
    end else dg_cnt <= 0;
  end
  assign stat_pins.overcurrent_flag_n  = !oc_q;
  assign stat_pins.usb_card_present_n  = usb_n;
  assign stat_pins.pcie_card_present_n = pcie_n;
endmodule

// ===== test/tb.sv
// Self-checking bench for the slot power host controller.
`timescale 1ns/100ps
module tb;
  import slot_power_pkg::*;
  localparam int WCYC = 16;
  localparam int CCYC = 64;
  logic clk = 0, reset = 1, clk_en = 1, aux_valid = 0, sd = 0, sb = 0;
  logic warm = 0, cold = 0, hold = 0, usb_n = 1, pcie_n = 1, oc_in = 0;
  ctrl_pins_t   cp;
  stat_pins_t   sp;
  slot_status_t st;
  logic         oe, m_oe, line, busy, pg_o;
  int           err_count = 0, cmp_count = 0, n;
  // Rows: {shutdown, standby, usb_n, pcie_n, pins[2:0], present bits}.
  logic [9:0]   rows [6] = '{10'h0f8, 10'h07e, 10'h0bd, 10'h137,
                             10'h327, 10'h2e8};
  // The line has a pull-up, so it is high unless someone pulls it.
  assign line = !m_oe && (oe ? pg_o : 1'b1);
  slot_power_host #(.COLD_HOLD_CYC(CCYC), .WARM_CYC(WCYC)) u_dut (
    .clk(clk), .reset(reset), .clk_en(clk_en), .aux_valid(aux_valid),
    .user_shutdown(sd), .user_standby(sb), .user_warm_reset(warm),
    .user_cold_extend(cold), .user_hold_power_good(hold),
    .ctrl_pins(cp), .stat_pins(sp), .refclk_enable_power_good_i(line),
    .refclk_enable_power_good_o(pg_o), .refclk_enable_power_good_oe(oe),
    .slot_status(st), .warm_busy(busy));
  slot_switch_model u_sw (
    .clk(clk), .reset(reset), .ctrl_pins(cp), .stat_pins(sp),
    .pg_line(line), .pg_oe(m_oe), .usb_n(usb_n), .pcie_n(pcie_n),
    .oc_in(oc_in));
  initial forever #2.5 clk = ~clk;
  task automatic chk(string nm, logic [5:0] e, logic [5:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait for a full status word; a timeout ends the run.
  task automatic wait_st(logic [5:0] e);
    n = 0;
    while (st !== e && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("status", e, st);
    if (st !== e) end_sim();
  endtask
  initial begin
    repeat (11) @(posedge clk);
    #1 chk("pins", 6'h0, cp);
    @(posedge clk);
    reset     <= 1'b0;
    aux_valid <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk);
      {sd, sb, usb_n, pcie_n} <= rows[i][9:6];
      repeat (3) @(posedge clk);
      #1 chk("pins", rows[i][5:3], cp);
      chk("present", rows[i][2:0], st[5:3]);
    end
    // Power up with both card kinds; reset lags the power good rise.
    @(posedge clk) {sd, sb, usb_n, pcie_n} <= 4'h0;
    wait_st(6'h3e);
    wait_st(6'h3c);
    // Host holds power good low; release must restart the timer.
    @(posedge clk) hold <= 1'b1;
    wait_st(6'h3a);
    chk("pg_o", 6'h0, pg_o);
    // Release with the stretch on: the rise starts a cold hold.
    @(posedge clk);
    hold <= 1'b0;
    cold <= 1'b1;
    wait_st(6'h3e);
    repeat (5) @(posedge clk);
    #1 chk("held", 6'h3e, st);
    // The switch alone would have let go by now; the stretch holds on.
    repeat (45) @(posedge clk);
    #1 chk("stretch", 6'h3e, st);
    chk("busy", 6'h1, busy);
    wait_st(6'h3c);
    @(posedge clk) cold <= 1'b0;
    // Warm reset keeps rails and power good while card reset pulses.
    @(posedge clk) warm <= 1'b1;
    @(posedge clk) warm <= 1'b0;
    wait_st(6'h3e);
    repeat (WCYC - 4) @(posedge clk);
    #1 chk("pulse", 6'h3e, st);
    chk("busy", 6'h1, busy);
    wait_st(6'h3c);
    chk("busy", 6'h0, busy);
    @(posedge clk) oc_in <= 1'b1;
    wait_st(6'h3d);
    @(posedge clk) oc_in <= 1'b0;
    wait_st(6'h3c);
    // Clock enable low freezes the pins; the shutdown waits for it.
    @(posedge clk);
    clk_en <= 1'b0;
    sd     <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("frozen", 6'h7, cp);
    @(posedge clk) clk_en <= 1'b1;
    @(posedge clk);
    #1 chk("pins", 6'h5, cp);
    // Losing the aux supply forces every control pin low.
    @(posedge clk) aux_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("pins", 6'h0, cp);
    end_sim();
  end
endmodule
